/* rxphy_regs.svh */
/*
 * Offsets, field positions, reset values and serial frame counts of the
 * receive physical layer control bank.
 * Assumes inclusion by bare name; holds definitions only.
 */
`ifndef RXPHY_REGS_SVH
`define RXPHY_REGS_SVH
// ****************************************
// register offsets
// ****************************************
`define ADDR_CDR_DIV 15'h162
`define ADDR_EQ_CTRL 15'h167
`define ADDR_LANE0_GAIN 15'h168
`define ADDR_LANE1_GAIN 15'h169
`define ADDR_LANE2_GAIN 15'h16a
`define ADDR_LANE3_GAIN 15'h16b
`define ADDR_TERM_CM 15'h170
`define ADDR_TERM_CTRL 15'h171
`define ADDR_SYNC_CFG 15'h17d
`define ADDR_SYNC_TEST 15'h17e
`define ADDR_REC_MON 15'h185
`define ADDR_EQ_MON 15'h187
// ****************************************
// reset values
// ****************************************
`define RST_CDR_DIV 8'h02
`define RST_EQ_CTRL 8'h1f
`define RST_GAIN 8'h04
`define RST_TERM_CM 8'h25
`define RST_TERM_CTRL 8'h0f
`define RST_SYNC_CFG 8'h80
`define RST_SYNC_TEST 8'h00
`define RST_REC_MON 4'hf
`define RST_EQ_MON 5'h1f
// ****************************************
// field positions
// ****************************************
`define LOW_SPEED_BIT 7
`define AUTOZERO_BIT 4
`define RX_USE_BIT 5
`define SYNC_ON_BIT 7
`define TEST_ON_BIT 7
// ****************************************
// serial frame bit counts
// ****************************************
`define HEAD_LAST 5'h0f
`define DATA_FIRST 5'h10
`define FRAME_LAST 5'h17
`endif

/* rxphy_pkg.sv */
/*
 * Types shared by the receive physical layer control bank.
 * Assumes nothing of its surroundings.
 */
package rxphy_pkg;
    typedef enum logic [2:0] {SPI_IDLE, SPI_HEAD, SPI_LOAD, SPI_DATA, SPI_DONE} spi_state_e;
    typedef struct packed {logic en; logic [14:0] addr; logic [7:0] data;} reg_wr_s;
    typedef struct packed {
        logic recovery_low_speed_on;
        logic [1:0] recovery_predivider_ratio;
        logic [4:0] recovery_loop_divider_ratio;
        logic equalizer_autozero_on;
        logic [3:0] equalizer_on;
        logic [3:0][2:0] equalizer_gain_sel;
        logic termination_rx_use_sel;
        logic [4:0] termination_cm_reference;
        logic [3:0] input_high_impedance;
        logic [3:0] termination_on;
        logic sync_buffer_on;
        logic [2:0] sync_buffer_cm_level;
        logic [2:0] sync_buffer_swing;
        logic sync_test_mode_on;
        logic [1:0] sync_test_source_sel;
    } phy_cfg_s;
    typedef struct packed {
        logic [2:0] meta;
        logic [2:0] sync;
        logic [2:0] prev;
        spi_state_e state;
        logic [4:0] count;
        logic [15:0] head;
        logic [7:0] dshift;
        logic [7:0] oshift;
        logic sdo_oe;
        reg_wr_s wr;
    } spi_s;
    typedef struct packed {logic [3:0] meta; logic [3:0] sync; logic out;} sync_s;
    typedef struct packed {
        phy_cfg_s cfg;
        logic [3:0] rec_meta;
        logic [3:0] rec_sync;
        logic [4:0] eq_status;
    } top_s;
endpackage

/* rxphy_spi_slave.sv */
/*
 * Serial control port slave: 16-bit header (read flag, 15-bit address)
 * then one data byte, MSB first, sampled on rising serial clock.
 * Assumes the serial clock runs at most one eighth of clk_i.
 */
`timescale 1ns/10ps
`include "rxphy_regs.svh"
module rxphy_spi_slave (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic sdi_i,
    input wire logic [7:0] rd_data_i,
    output logic [14:0] rd_addr_o,
    output rxphy_pkg::reg_wr_s wr_o,
    output logic sdo_o,
    output logic sdo_oe_o
);
    import rxphy_pkg::*;
    spi_s st_reg;
    spi_s st_next;
    logic rise;
    logic fall;
    // pins at idle levels, so reset shows no false select
    localparam spi_s SPI_RST = '{meta: 3'h2, sync: 3'h2, prev: 3'h2, state: SPI_IDLE,
        count: 5'h00, head: 16'h0000, dshift: 8'h00, oshift: 8'h00, sdo_oe: 1'h0, wr: '0};
    always_comb begin
        st_next = st_reg;
        st_next.wr.en = 1'b0;
        // pin order: clock, select, data
        st_next.meta = {sclk_i, cs_n_i, sdi_i};
        st_next.sync = st_reg.meta;
        st_next.prev = st_reg.sync;
        rise = st_reg.sync[2] & ~st_reg.prev[2];
        fall = ~st_reg.sync[2] & st_reg.prev[2];
        if (st_reg.sync[1]) begin
            st_next.state = SPI_IDLE;
            st_next.count = 5'h00;
            st_next.sdo_oe = 1'b0;
        end else begin
            case (st_reg.state)
                SPI_IDLE: st_next.state = SPI_HEAD;
                SPI_HEAD: if (rise) begin
                    st_next.head = {st_reg.head[14:0], st_reg.sync[0]};
                    st_next.count = 5'(st_reg.count + 5'h01);
                    if (st_reg.count == `HEAD_LAST) st_next.state = SPI_LOAD;
                end
                SPI_LOAD: begin
                    st_next.oshift = rd_data_i;
                    st_next.sdo_oe = st_reg.head[15];
                    st_next.state = SPI_DATA;
                end
                SPI_DATA: begin
                    if (rise) begin
                        st_next.dshift = {st_reg.dshift[6:0], st_reg.sync[0]};
                        st_next.count = 5'(st_reg.count + 5'h01);
                        if (st_reg.count == `FRAME_LAST) begin
                            st_next.state = SPI_DONE;
                            st_next.wr.en = ~st_reg.head[15];
                            st_next.wr.addr = st_reg.head[14:0];
                            st_next.wr.data = {st_reg.dshift[6:0], st_reg.sync[0]};
                        end
                    end
                    if (fall && st_reg.count > `DATA_FIRST) st_next.oshift = {st_reg.oshift[6:0], 1'b0};
                end
                SPI_DONE: st_next.state = SPI_DONE;
                default: st_next.state = SPI_IDLE;
            endcase
        end
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) st_reg <= SPI_RST;
        else st_reg <= st_next;
    end
    assign rd_addr_o = st_reg.head[14:0];
    assign wr_o = st_reg.wr;
    assign sdo_o = st_reg.oshift[7];
    assign sdo_oe_o = st_reg.sdo_oe;
endmodule

/* rxphy_sync_mux.sv */
/*
 * Link synchronisation output source select with recovered clock test mux.
 * Assumes link_sync_i comes from logic on clk_i; rclk_i are asynchronous.
 */
`timescale 1ns/10ps
module rxphy_sync_mux (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] rclk_i,
    input wire logic link_sync_i,
    input wire logic buf_on_i,
    input wire logic test_on_i,
    input wire logic [1:0] sel_i,
    output logic sync_o
);
    import rxphy_pkg::*;
    sync_s st_reg;
    sync_s st_next;
    always_comb begin
        st_next.meta = rclk_i;
        st_next.sync = st_reg.meta;
        // powered-down buffer drives low
        if (!buf_on_i) st_next.out = 1'b0;
        else if (test_on_i) st_next.out = st_reg.sync[sel_i];
        else st_next.out = link_sync_i;
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) st_reg <= '0;
        else st_reg <= st_next;
    end
    assign sync_o = st_reg.out;
    AST_SYNC_NORMAL: assert property (@(posedge clk_i) disable iff (rst_i)
        buf_on_i && !test_on_i |=> sync_o == $past(link_sync_i)) else $error("normal sync lost");
    for (genvar k = 0; k < 4; k++) begin : g_lane
        AST_TEST_ROUTE: assert property (@(posedge clk_i) disable iff (rst_i)
            buf_on_i && test_on_i && sel_i == 2'(k) |=> sync_o == $past(rclk_i[k], 3))
            else $error("wrong recovered clock routed");
    end
endmodule

/* rxphy_ctrl_top.sv */
/*
 * Receive physical layer control bank: recovery divider, equalizer,
 * termination and synchronisation buffer settings, plus monitors.
 * Assumes a serial control port master and analog lanes outside.
 */
`timescale 1ns/10ps
`include "rxphy_regs.svh"

module rxphy_ctrl_top (
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    input wire logic SCLK_I,
    input wire logic CS_N_I,
    input wire logic SDI_I,
    output logic SDO_O,
    output logic SDO_OE_O,
    input wire logic LINK_SYNC_I,
    input wire logic [3:0] RECOVERED_CLOCK_I,
    input wire logic [3:0] LANE_RECOVERY_ON_I,
    output rxphy_pkg::phy_cfg_s PHY_CFG_O,
    output logic SYNC_O
);
    import rxphy_pkg::*;

    // ****************************************
    // register write decode
    // ****************************************
    function automatic phy_cfg_s apply_write(phy_cfg_s c, logic [14:0] a, logic [7:0] d);
        phy_cfg_s r;
        r = c;
        case (a)
            `ADDR_CDR_DIV: begin
                r.recovery_low_speed_on = d[`LOW_SPEED_BIT];
                r.recovery_predivider_ratio = d[6:5];
                r.recovery_loop_divider_ratio = d[4:0];
            end
            `ADDR_EQ_CTRL: begin
                // bit 5 is dropped so it always reads 0
                r.equalizer_autozero_on = d[`AUTOZERO_BIT];
                r.equalizer_on = d[3:0];
            end
            `ADDR_LANE0_GAIN: r.equalizer_gain_sel[0] = d[2:0];
            `ADDR_LANE1_GAIN: r.equalizer_gain_sel[1] = d[2:0];
            `ADDR_LANE2_GAIN: r.equalizer_gain_sel[2] = d[2:0];
            `ADDR_LANE3_GAIN: r.equalizer_gain_sel[3] = d[2:0];
            `ADDR_TERM_CM: begin
                // stored as written; software keeps it at 1
                r.termination_rx_use_sel = d[`RX_USE_BIT];
                r.termination_cm_reference = d[4:0];
            end
            `ADDR_TERM_CTRL: begin
                r.input_high_impedance = d[7:4];
                r.termination_on = d[3:0];
            end
            `ADDR_SYNC_CFG: begin
                r.sync_buffer_on = d[`SYNC_ON_BIT];
                r.sync_buffer_cm_level = d[6:4];
                r.sync_buffer_swing = d[2:0];
            end
            `ADDR_SYNC_TEST: begin
                r.sync_test_mode_on = d[`TEST_ON_BIT];
                r.sync_test_source_sel = d[5:4];
            end
            // monitors and unmapped offsets ignore writes
            default: r = c;
        endcase
        return r;
    endfunction

    // ****************************************
    // register read mux
    // ****************************************
    function automatic logic [7:0] read_reg(top_s s, logic [14:0] a);
        logic [7:0] d;
        d = 8'h00;
        case (a)
            `ADDR_CDR_DIV: begin
                d[`LOW_SPEED_BIT] = s.cfg.recovery_low_speed_on;
                d[6:5] = s.cfg.recovery_predivider_ratio;
                d[4:0] = s.cfg.recovery_loop_divider_ratio;
            end
            `ADDR_EQ_CTRL: begin
                d[`AUTOZERO_BIT] = s.cfg.equalizer_autozero_on;
                d[3:0] = s.cfg.equalizer_on;
            end
            `ADDR_LANE0_GAIN: d[2:0] = s.cfg.equalizer_gain_sel[0];
            `ADDR_LANE1_GAIN: d[2:0] = s.cfg.equalizer_gain_sel[1];
            `ADDR_LANE2_GAIN: d[2:0] = s.cfg.equalizer_gain_sel[2];
            `ADDR_LANE3_GAIN: d[2:0] = s.cfg.equalizer_gain_sel[3];
            `ADDR_TERM_CM: begin
                d[`RX_USE_BIT] = s.cfg.termination_rx_use_sel;
                d[4:0] = s.cfg.termination_cm_reference;
            end
            `ADDR_TERM_CTRL: begin
                d[7:4] = s.cfg.input_high_impedance;
                d[3:0] = s.cfg.termination_on;
            end
            `ADDR_SYNC_CFG: begin
                d[`SYNC_ON_BIT] = s.cfg.sync_buffer_on;
                d[6:4] = s.cfg.sync_buffer_cm_level;
                d[2:0] = s.cfg.sync_buffer_swing;
            end
            `ADDR_SYNC_TEST: begin
                d[`TEST_ON_BIT] = s.cfg.sync_test_mode_on;
                d[5:4] = s.cfg.sync_test_source_sel;
            end
            `ADDR_REC_MON: d[3:0] = s.rec_sync;
            `ADDR_EQ_MON: d[4:0] = s.eq_status;
            default: d = 8'h00;
        endcase
        return d;
    endfunction

    // ****************************************
    // reset state
    // ****************************************
    function automatic top_s reset_state();
        top_s s;
        s = '0;
        s.cfg = apply_write(s.cfg, `ADDR_CDR_DIV, `RST_CDR_DIV);
        s.cfg = apply_write(s.cfg, `ADDR_EQ_CTRL, `RST_EQ_CTRL);
        s.cfg = apply_write(s.cfg, `ADDR_LANE0_GAIN, `RST_GAIN);
        s.cfg = apply_write(s.cfg, `ADDR_LANE1_GAIN, `RST_GAIN);
        s.cfg = apply_write(s.cfg, `ADDR_LANE2_GAIN, `RST_GAIN);
        s.cfg = apply_write(s.cfg, `ADDR_LANE3_GAIN, `RST_GAIN);
        s.cfg = apply_write(s.cfg, `ADDR_TERM_CM, `RST_TERM_CM);
        s.cfg = apply_write(s.cfg, `ADDR_TERM_CTRL, `RST_TERM_CTRL);
        s.cfg = apply_write(s.cfg, `ADDR_SYNC_CFG, `RST_SYNC_CFG);
        s.cfg = apply_write(s.cfg, `ADDR_SYNC_TEST, `RST_SYNC_TEST);
        s.rec_meta = `RST_REC_MON;
        s.rec_sync = `RST_REC_MON;
        s.eq_status = `RST_EQ_MON;
        return s;
    endfunction

    localparam top_s TOP_RST = reset_state();

    top_s state_reg;
    top_s state_next;
    reg_wr_s wr;
    logic [14:0] rd_addr;
    logic [7:0] rd_data;

    // ****************************************
    // state update
    // ****************************************
    always_comb begin
        state_next = state_reg;
        if (wr.en) begin
            state_next.cfg = apply_write(state_reg.cfg, wr.addr, wr.data);
        end
        state_next.rec_meta = LANE_RECOVERY_ON_I;
        state_next.rec_sync = state_reg.rec_meta;
        // follows applied settings every cycle
        state_next.eq_status = {state_reg.cfg.equalizer_autozero_on,
                                state_reg.cfg.equalizer_on};
    end

    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state_reg <= TOP_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rd_data = read_reg(state_reg, rd_addr);
    assign PHY_CFG_O = state_reg.cfg;

    // ****************************************
    // serial port and sync output
    // ****************************************
    rxphy_spi_slave u_spi (
        .clk_i(REF_CLK_I),
        .rst_i(RST_I),
        .sclk_i(SCLK_I),
        .cs_n_i(CS_N_I),
        .sdi_i(SDI_I),
        .rd_data_i(rd_data),
        .rd_addr_o(rd_addr),
        .wr_o(wr),
        .sdo_o(SDO_O),
        .sdo_oe_o(SDO_OE_O)
    );

    rxphy_sync_mux u_sync (
        .clk_i(REF_CLK_I),
        .rst_i(RST_I),
        .rclk_i(RECOVERED_CLOCK_I),
        .link_sync_i(LINK_SYNC_I),
        .buf_on_i(state_reg.cfg.sync_buffer_on),
        .test_on_i(state_reg.cfg.sync_test_mode_on),
        .sel_i(state_reg.cfg.sync_test_source_sel),
        .sync_o(SYNC_O)
    );

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (RST_I);

    sequence s_wr_at(logic [14:0] a);
        wr.en && wr.addr == a;
    endsequence

    AST_LOW_SPEED: assert property (
        s_wr_at(`ADDR_CDR_DIV) |=> PHY_CFG_O.recovery_low_speed_on == $past(wr.data[7]))
        else $error("low speed bit not applied");
    AST_DIVIDERS: assert property (
        s_wr_at(`ADDR_CDR_DIV) |=> {PHY_CFG_O.recovery_predivider_ratio,
        PHY_CFG_O.recovery_loop_divider_ratio} == $past(wr.data[6:0]))
        else $error("divider ratios not applied");
    AST_AUTOZERO: assert property (
        s_wr_at(`ADDR_EQ_CTRL) |=> PHY_CFG_O.equalizer_autozero_on == $past(wr.data[4]))
        else $error("auto-zero not applied");
    AST_EQ_RESERVED: assert property (
        rd_addr == `ADDR_EQ_CTRL || rd_addr == `ADDR_EQ_MON |-> rd_data[7:5] == 3'h0)
        else $error("reserved equalizer bits read non-zero");
    AST_EQ_ON: assert property (
        s_wr_at(`ADDR_EQ_CTRL) |=> PHY_CFG_O.equalizer_on == $past(wr.data[3:0]))
        else $error("lane equalizer enables not applied");
    AST_GAIN0: assert property (
        s_wr_at(`ADDR_LANE0_GAIN) |=> PHY_CFG_O.equalizer_gain_sel[0] == $past(wr.data[2:0])
        && $stable(PHY_CFG_O.equalizer_gain_sel[3:1]))
        else $error("lane 0 gain not applied alone");
    AST_GAIN3: assert property (
        s_wr_at(`ADDR_LANE3_GAIN) |=> PHY_CFG_O.equalizer_gain_sel[3] == $past(wr.data[2:0])
        && $stable(PHY_CFG_O.equalizer_gain_sel[2:0]))
        else $error("lane 3 gain not applied alone");
    AST_CM_REF: assert property (
        s_wr_at(`ADDR_TERM_CM) |=> PHY_CFG_O.termination_cm_reference == $past(wr.data[4:0]))
        else $error("common-mode reference not applied");
    AST_TERM: assert property (
        s_wr_at(`ADDR_TERM_CTRL) |=> {PHY_CFG_O.input_high_impedance,
        PHY_CFG_O.termination_on} == $past(wr.data))
        else $error("termination control not applied");
    AST_SYNC_CFG: assert property (
        s_wr_at(`ADDR_SYNC_CFG) |=> PHY_CFG_O.sync_buffer_on == $past(wr.data[7])
        && PHY_CFG_O.sync_buffer_cm_level == $past(wr.data[6:4])
        && PHY_CFG_O.sync_buffer_swing == $past(wr.data[2:0]))
        else $error("sync buffer config not applied");
    AST_EQ_MON: assert property (
        s_wr_at(`ADDR_EQ_CTRL) |=> ##1 state_reg.eq_status == $past(wr.data[4:0], 2))
        else $error("equalizer monitor does not follow setting");
    AST_REC_MON: assert property (
        rd_addr == `ADDR_REC_MON |-> rd_data == {4'h0, $past(LANE_RECOVERY_ON_I, 2)})
        else $error("recovery monitor wrong");
    AST_MON_RO: assert property (
        s_wr_at(`ADDR_EQ_MON) or s_wr_at(`ADDR_REC_MON) |=> $stable(PHY_CFG_O)
        ##1 $stable(state_reg.eq_status))
        else $error("monitor write had an effect");
    AST_GAIN1: assert property (
        s_wr_at(`ADDR_LANE1_GAIN) |=>
        PHY_CFG_O.equalizer_gain_sel[1] ==
        $past(wr.data[2:0]))
        else $error("lane 1 gain not applied");
    AST_GAIN2: assert property (
        s_wr_at(`ADDR_LANE2_GAIN) |=>
        PHY_CFG_O.equalizer_gain_sel[2] ==
        $past(wr.data[2:0]))
        else $error("lane 2 gain not applied");
    AST_SYNC_TEST: assert property (
        s_wr_at(`ADDR_SYNC_TEST) |=>
        PHY_CFG_O.sync_test_mode_on == $past(wr.data[7])
        && PHY_CFG_O.sync_test_source_sel ==
        $past(wr.data[5:4]))
        else $error("sync test select not applied");
    AST_SYNC_OFF: assert property (
        !PHY_CFG_O.sync_buffer_on |=> !SYNC_O)
        else $error("sync out high with buffer off");
    AST_EQ_TRACK: assert property (
        1'h1 |=> state_reg.eq_status ==
        $past({PHY_CFG_O.equalizer_autozero_on,
        PHY_CFG_O.equalizer_on}))
        else $error("equalizer monitor not tracking");

    // ****************************************
    // read mux checks
    // ****************************************
    AST_RD_DIV: assert property (
        rd_addr == `ADDR_CDR_DIV |->
        rd_data == {PHY_CFG_O.recovery_low_speed_on,
        PHY_CFG_O.recovery_predivider_ratio,
        PHY_CFG_O.recovery_loop_divider_ratio})
        else $error("divider readback wrong");
    AST_RD_EQ: assert property (
        rd_addr == `ADDR_EQ_CTRL |->
        rd_data == {3'h0,
        PHY_CFG_O.equalizer_autozero_on,
        PHY_CFG_O.equalizer_on})
        else $error("equalizer readback wrong");
    for (genvar k = 0; k < 4; k++) begin : g_gain
        AST_RD_GAIN: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
            rd_addr == 15'(`ADDR_LANE0_GAIN + k) |->
            rd_data == {5'h00,
            PHY_CFG_O.equalizer_gain_sel[k]})
            else $error("gain readback wrong");
    end
    AST_RD_CM: assert property (
        rd_addr == `ADDR_TERM_CM |->
        rd_data == {2'h0, PHY_CFG_O.termination_rx_use_sel,
        PHY_CFG_O.termination_cm_reference})
        else $error("common-mode readback wrong");
    AST_RD_TERM: assert property (
        rd_addr == `ADDR_TERM_CTRL |->
        rd_data == {PHY_CFG_O.input_high_impedance,
        PHY_CFG_O.termination_on})
        else $error("termination readback wrong");
    AST_RD_SYNC: assert property (
        rd_addr == `ADDR_SYNC_CFG |->
        rd_data == {PHY_CFG_O.sync_buffer_on,
        PHY_CFG_O.sync_buffer_cm_level, 1'h0,
        PHY_CFG_O.sync_buffer_swing})
        else $error("sync config readback wrong");
    AST_RD_TEST: assert property (
        rd_addr == `ADDR_SYNC_TEST |->
        rd_data == {PHY_CFG_O.sync_test_mode_on, 1'h0,
        PHY_CFG_O.sync_test_source_sel, 4'h0})
        else $error("sync test readback wrong");
    AST_RD_EQ_MON: assert property (
        rd_addr == `ADDR_EQ_MON |->
        rd_data == {3'h0, state_reg.eq_status})
        else $error("equalizer monitor readback wrong");
endmodule

/* rxphy_lane_model.sv */
/*
 * Lane side model: four free running recovered clocks and lane
 * recovery enables. Assumes the bench gives the reference clock.
 */
`timescale 1ns/10ps
module rxphy_lane_model (
    input wire logic clk_i,
    input wire logic [3:0] rec_on_i,
    output logic [3:0] rclk_o,
    output logic [3:0] rec_on_o
);
    // ********
    // lane k toggles every k+3 cycles, off the sampling edge
    // ********
    int cnt [4];
    initial begin
        rclk_o = 4'h0;
        rec_on_o = 4'hf;
        for (int k = 0; k < 4; k++)
            cnt[k] = 0;
    end
    always @(negedge clk_i) begin
        rec_on_o <= rec_on_i;
        for (int k = 0; k < 4; k++) begin
            cnt[k] <= (cnt[k] == k + 2) ? 0 : cnt[k] + 1;
            if (cnt[k] == k + 2)
                rclk_o[k] <= ~rclk_o[k];
        end
    end
endmodule

/* serial_rx_phy_control_regs_test.sv */
/*
 * Self-checking bench for the receive physical layer control bank.
 * Assumes rxphy_pkg and the lane model are compiled before it.
 */
`timescale 1ns/10ps
module serial_rx_phy_control_regs_test;
    import rxphy_pkg::*;
    logic ref_clk, rst, sclk, cs_n, sdi, link_sync, sdo, sdo_oe, sync_out;
    logic [3:0] rec_on_want, rclk, rec_on;
    phy_cfg_s cfg;
    int mismatches = 0;
    int samples_checked = 0;
    logic [14:0] adr [12] = '{15'h162, 15'h167, 15'h168, 15'h169, 15'h16a, 15'h16b,
        15'h170, 15'h171, 15'h17d, 15'h17e, 15'h185, 15'h187};
    logic [7:0] rst_val [12] = '{8'h02, 8'h1f, 8'h04, 8'h04, 8'h04, 8'h04, 8'h25, 8'h0f,
        8'h80, 8'h00, 8'h0f, 8'h1f};
    logic [7:0] wdat [10] = '{8'hb5, 8'h3a, 8'hff, 8'hfa, 8'hf3, 8'hfd, 8'hea, 8'h5c,
        8'hda, 8'h6f};
    logic [7:0] rbk [10] = '{8'hb5, 8'h1a, 8'h07, 8'h02, 8'h03, 8'h05, 8'h2a, 8'h5c,
        8'hd2, 8'h20};

    rxphy_ctrl_top DUT (.REF_CLK_I(ref_clk), .RST_I(rst), .SCLK_I(sclk), .CS_N_I(cs_n),
        .SDI_I(sdi), .SDO_O(sdo), .SDO_OE_O(sdo_oe), .LINK_SYNC_I(link_sync),
        .RECOVERED_CLOCK_I(rclk), .LANE_RECOVERY_ON_I(rec_on), .PHY_CFG_O(cfg),
        .SYNC_O(sync_out));
    rxphy_lane_model lanes (.clk_i(ref_clk), .rec_on_i(rec_on_want), .rclk_o(rclk),
        .rec_on_o(rec_on));

    initial begin
        ref_clk = 1'h0;
        forever #20 ref_clk = ~ref_clk;
    end

    // ********
    // compare and report
    // ********
    task automatic bad(input string msg);
        mismatches++;
        $display("BAD t=%0t %s", $time, msg);
    endtask
    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp)
            bad($sformatf("%s got %h exp %h", what, got, exp));
    endtask
    task automatic check1(input logic got, input logic exp, input string what);
        samples_checked++;
        if (got !== exp)
            bad($sformatf("%s got %b", what, got));
    endtask
    task automatic check_cfg(input phy_cfg_s exp);
        samples_checked++;
        if (cfg !== exp)
            bad($sformatf("settings %h exp %h", cfg, exp));
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ********
    // serial frame: rw, 15 address bits, 8 data bits, msb first
    // ********
    task automatic spi(input logic rw, input logic [14:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        logic [23:0] frame;
        frame = {rw, a, d};
        q = 8'h00;
        @(posedge ref_clk) cs_n <= 1'h0;
        repeat (3) @(posedge ref_clk);
        for (int i = 23; i >= 0; i--) begin
            sdi <= frame[i];
            repeat (6) @(posedge ref_clk);
            if (i < 8) begin
                @(negedge ref_clk);
                q[i] = sdo;
                @(posedge ref_clk);
            end
            sclk <= 1'h1;
            repeat (6) @(posedge ref_clk);
            sclk <= 1'h0;
        end
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk);
        check1(sdo_oe, rw, "read drive");
        @(posedge ref_clk) cs_n <= 1'h1;
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        check1(sdo_oe, 1'h0, "released");
    endtask
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] q;
        spi(1'h0, a, d, q);
    endtask
    task automatic rd_chk(input logic [14:0] a, input logic [7:0] e);
        logic [7:0] q;
        spi(1'h1, a, 8'h00, q);
        check8(q, e, $sformatf("reg %h", a));
    endtask

    // ********
    // scenarios
    // ********
    task automatic t_reset_values();
        for (int i = 0; i < 12; i++)
            rd_chk(adr[i], rst_val[i]);
        check_cfg({1'h0, 2'h0, 5'h02, 1'h1, 4'hf, {4{3'h4}}, 1'h1, 5'h05, 4'h0, 4'hf,
            1'h1, 3'h0, 3'h0, 1'h0, 2'h0});
        $display("done reset values");
    endtask
    task automatic t_write_readback();
        phy_cfg_s exp;
        exp = {1'h1, 2'h1, 5'h15, 1'h1, 4'ha, {3'h5, 3'h3, 3'h2, 3'h7}, 1'h1, 5'h0a,
            4'h5, 4'hc, 1'h1, 3'h5, 3'h2, 1'h0, 2'h2};
        for (int i = 0; i < 10; i++)
            wr(adr[i], wdat[i]);
        check_cfg(exp);
        for (int i = 0; i < 10; i++)
            rd_chk(adr[i], rbk[i]);
        wr(15'h100, 8'hff);
        check_cfg(exp);
        $display("done write readback");
    endtask
    task automatic t_monitors();
        wr(15'h167, 8'h05);
        rd_chk(15'h187, 8'h05);
        wr(15'h187, 8'hff);
        wr(15'h185, 8'h00);
        rd_chk(15'h187, 8'h05);
        check8({3'h0, cfg.equalizer_autozero_on, cfg.equalizer_on}, 8'h05, "eq");
        rec_on_want <= 4'h6;
        rd_chk(15'h185, 8'h06);
        rd_chk(15'h100, 8'h00);
        $display("done monitors");
    endtask
    task automatic t_sync();
        logic [7:0] pat;
        logic prev;
        int n;
        pat = 8'hb2;
        wr(15'h17e, 8'h00);
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk) link_sync <= pat[i];
            @(negedge ref_clk);
            if (i > 0)
                check1(sync_out, pat[i - 1], "link");
        end
        for (int k = 0; k < 4; k++) begin
            wr(15'h17e, {4'(8 + k), 4'h0});
            n = 0;
            @(negedge ref_clk);
            prev = sync_out;
            repeat (120) begin
                @(negedge ref_clk);
                if (sync_out !== prev)
                    n++;
                prev = sync_out;
            end
            check1(n >= 120 / (k + 3) - 1 && n <= 120 / (k + 3) + 1, 1'h1, "lane");
        end
        wr(15'h17d, 8'h5a);
        n = 0;
        repeat (40) begin
            @(negedge ref_clk);
            if (sync_out !== 1'h0)
                n++;
        end
        check1(n == 0, 1'h1, "buffer off");
        check8({cfg.sync_buffer_on, cfg.sync_buffer_cm_level, 1'h0, cfg.sync_buffer_swing},
            8'h52, "sync cfg");
        $display("done sync output");
    endtask

    initial begin
        repeat (100000) @(posedge ref_clk);
        bad("watchdog");
        tally_and_finish();
    end
    initial begin
        rst = 1'h1;
        sclk = 1'h0;
        cs_n = 1'h1;
        sdi = 1'h0;
        link_sync = 1'h0;
        rec_on_want = 4'hf;
        repeat (3) @(posedge ref_clk);
        rst <= 1'h0;
        t_reset_values();
        t_write_readback();
        t_monitors();
        t_sync();
        tally_and_finish();
    end
endmodule
